/* File: bench/sbcl_board.sv */
// Board model: strap resistors or host GPIOs resolving the pad levels
`timescale 1ns/100ps
module sbcl_board (
    input  wire        clk_i,
    input  wire  [5:0] oe_i,
    input  wire  [5:0] o_i,
    input  wire  [5:0] pu_i,
    input  wire  [5:0] pd_i,
    input  wire  [5:0] drv_en_i,
    input  wire  [5:0] drv_val_i,
    output logic [5:0] pad_o
);
    logic tog = 1'b0;
    always @(posedge clk_i) tog <= ~tog;
    always @* begin
        for (int b = 0; b < 6; b++) begin
            if (oe_i[b]) pad_o[b] = o_i[b];
            else if (drv_en_i[b]) pad_o[b] = drv_val_i[b];
            else if (pu_i[b] | pd_i[b]) pad_o[b] = pu_i[b];
            // Unpulled floating line wanders, never a stale value
            else pad_o[b] = tog ^ b[0];
        end
    end
endmodule // sbcl_board

/* File: bench/sbcl_props.sv */
// Checker for the boot strap latch ports
`timescale 1ns/100ps
`include "sbcl_regs.vh"
module sbcl_props (
    // Clock and reset
    input wire                     core_clk_i,
    input wire                     nrst_i,
    input wire                     chip_en_i,
    // Pads
    input wire [`SBCL_STRAP_MSB:0] strap_pad_o,
    input wire [`SBCL_STRAP_MSB:0] strap_pad_oe_o,
    input wire [`SBCL_STRAP_MSB:0] strap_pull_up_o,
    input wire [`SBCL_STRAP_MSB:0] strap_pull_dn_o,
    input wire [`SBCL_STRAP_MSB:0] func_out_i,
    input wire [`SBCL_STRAP_MSB:0] func_oe_i,
    input wire [`SBCL_STRAP_MSB:0] func_in_o,
    // Settings
    input wire                     uart0_tx_i,
    input wire                     uart0_transmit_o,
    input wire                     boot_spi_flash_o,
    input wire                     boot_download_o,
    input wire                     boot_log_en_o,
    input wire                     straps_valid_o,
    input wire                     core_run_o,
    // APB
    input wire                     psel,
    input wire                     penable,
    input wire                     pwrite,
    input wire [`SBCL_ADDR_W-1:0]  paddr,
    input wire [31:0]              prdata,
    input wire                     pslverr
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    chk_pull_hold: assert property (
        !core_run_o |-> strap_pull_up_o == 6'h1A &&
        strap_pull_dn_o == 6'h25 && strap_pad_oe_o == 6'h00)
        else $error("pulls or drive wrong while holding");
    chk_pull_run: assert property (
        core_run_o |-> (strap_pull_up_o | strap_pull_dn_o) == 6'h00)
        else $error("pulls left on while running");
    chk_pad_run: assert property (
        core_run_o |-> strap_pad_oe_o == func_oe_i &&
        strap_pad_o == func_out_i)
        else $error("pads not handed to normal function");
    chk_func_hold: assert property (
        !core_run_o |-> func_in_o == 6'h00)
        else $error("pad input reaches function while holding");
    chk_valid_run: assert property (
        $rose(straps_valid_o) |-> $past(core_run_o))
        else $error("valid rose without capture");
    chk_straps_kept: assert property (
        straps_valid_o ##1 straps_valid_o |->
        $stable({boot_spi_flash_o, boot_download_o, boot_log_en_o}))
        else $error("latched boot settings changed");
    chk_en_drop: assert property (
        $fell(chip_en_i) |-> ##[1:4] !core_run_o)
        else $error("run kept after chip enable fell");
    chk_log_pass: assert property (
        boot_log_en_o |-> uart0_transmit_o == uart0_tx_i)
        else $error("log output blocked");
    chk_rd_idle: assert property (
        !(psel && penable) |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("read data outside access");
    chk_status_ro: assert property (
        psel && penable && pwrite && paddr == 12'h000 |-> pslverr)
        else $error("status write not refused");
endmodule // sbcl_props
bind sbcl_top sbcl_props i_props (.core_clk_i, .nrst_i, .chip_en_i,
    .strap_pad_o, .strap_pad_oe_o, .strap_pull_up_o, .strap_pull_dn_o,
    .func_out_i, .func_oe_i, .func_in_o, .uart0_tx_i, .uart0_transmit_o,
    .boot_spi_flash_o, .boot_download_o, .boot_log_en_o, .straps_valid_o,
    .core_run_o, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr);

/* File: bench/tb_strap_boot_config_latch.sv */
// Testbench for the boot strap latch
`timescale 1ns/100ps
module tb_strap_boot_config_latch;
    logic core_clk_i = 0, nrst_i = 0, ce_i = 1, chip_en_i = 1;
    logic uart0_tx_i = 0, boot_done_i = 0, psel = 0, penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'h0000_5AAC;
    logic [5:0] func_out_i = 0, func_oe_i = 0, drv_en = 0, drv_val = 0;
    wire [5:0] strap_pad_i, strap_pad_o, strap_pad_oe_o, func_in_o;
    wire [5:0] strap_pull_up_o, strap_pull_dn_o;
    wire uart0_transmit_o, flash_vsel_1v8_o, boot_spi_flash_o;
    wire boot_download_o, boot_log_en_o, sdio_in_rising_o, pready;
    wire sdio_out_rising_o, straps_valid_o, core_run_o, pslverr;
    wire [31:0] prdata;
    int bad_count = 0, comparisons = 0;
    logic [32:0] rq[$];
    logic [32:0] dq[$];
    logic prev_valid = 0;
    always #5 core_clk_i = ~core_clk_i;
    sbcl_top i_dut (.core_clk_i, .nrst_i, .ce_i, .chip_en_i, .strap_pad_i,
        .strap_pad_o, .strap_pad_oe_o, .strap_pull_up_o, .strap_pull_dn_o,
        .func_out_i, .func_oe_i, .func_in_o(), .uart0_tx_i, .boot_done_i,
        .uart0_transmit_o, .flash_vsel_1v8_o, .boot_spi_flash_o,
        .boot_download_o, .boot_log_en_o, .sdio_in_rising_o,
        .sdio_out_rising_o, .straps_valid_o, .core_run_o, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
    sbcl_board i_board (.clk_i(core_clk_i), .oe_i(strap_pad_oe_o),
        .o_i(strap_pad_o), .pu_i(strap_pull_up_o), .pd_i(strap_pull_dn_o),
        .drv_en_i(drv_en), .drv_val_i(drv_val), .pad_o(strap_pad_i));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task tally_and_finish();
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task check(string what, logic [32:0] e, logic [32:0] s);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    task apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] e);
        int i;
        @(posedge core_clk_i);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        rq.push_back(e);
        @(posedge core_clk_i);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk_i);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            bad_count++;
            tally_and_finish();
        end
        psel <= 0; penable <= 0;
    endtask
    task wait_valid(logic v);
        int k;
        for (k = 0; k < 100 && straps_valid_o !== v; k++)
            @(posedge core_clk_i);
        if (straps_valid_o !== v) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    // Second process: compares each answer with the oldest note
    always @(posedge core_clk_i) begin
        if (psel && penable && pready === 1'b1)
            check("apb", rq.pop_front(),
                  {pslverr, pwrite ? 32'h0 : prdata});
        if (straps_valid_o === 1'b1 && !prev_valid)
            check("decode", dq.pop_front(), {26'h0, flash_vsel_1v8_o,
                boot_spi_flash_o, boot_download_o, boot_log_en_o,
                sdio_in_rising_o, sdio_out_rising_o, uart0_transmit_o});
        prev_valid <= straps_valid_o === 1'b1;
    end
    initial begin
        logic [5:0] s, f, e;
        logic dl;
        for (int n = 0; n < 10; n++) begin
            s = rnd();
            f = (n == 0) ? 6'h3F : (n < 6) ? 6'h00 : rnd();
            if (n >= 2 && n < 6) s[4:1] = {n[1:0], n[1:0]};
            e = (s & ~f) | (6'h1A & f);
            dl = ~e[1] & ~e[2];
            @(posedge core_clk_i);
            drv_en <= ~f; drv_val <= s; func_oe_i <= 0;
            if (n == 0) begin
                repeat (11) @(posedge core_clk_i);
                nrst_i <= 1;
            end else begin
                chip_en_i <= 0;
                // old latch must drop before the enable returns
                wait_valid(1'b0);
                chip_en_i <= 1;
            end
            dq.push_back({e[0], e[1], dl, e[3], e[3], e[4], ~e[3]});
            wait_valid(1'b1);
            drv_val <= ~s; drv_en <= 6'h3F;
            func_oe_i <= rnd(); func_out_i <= rnd();
            repeat (4) @(posedge core_clk_i);
            apb(0, 12'h000, 0, {25'h1, 2'h0, e});
            apb(0, 12'h008, 0, {27'h1, e[3], dl, e[1], e[4], e[3], e[0]});
        end
        boot_done_i <= 1;
        @(posedge core_clk_i);
        boot_done_i <= 0;
        apb(1, 12'h004, 32'h0000_001F, 33'h0);
        apb(0, 12'h004, 0, 33'h0_0000_001F);
        apb(0, 12'h008, 0, {27'h0, e[3], dl, e[1], 3'h7});
        apb(1, 12'h000, 32'hFFFF_FFFF, {1'b1, 32'h0});
        apb(0, 12'h00C, 0, {1'b1, 32'h0});
        // Clock enable low: the write must not be taken
        ce_i <= 0;
        apb(1, 12'h004, 32'h0, 33'h0);
        @(posedge core_clk_i);
        ce_i <= 1;
        apb(0, 12'h004, 0, 33'h0_0000_001F);
        apb(0, 12'h000, 0, {25'h1, 2'h0, e});
        tally_and_finish();
    end
endmodule // tb_strap_boot_config_latch

/* File: core/sbcl_sync.v */
// Two-stage synchroniser for one asynchronous input
`timescale 1ns/100ps
module sbcl_sync (
    // Clock and reset
    input  wire core_clk_i,
    input  wire nrst_i,
    input  wire ce_i,
    // Data
    input  wire d_i,
    output wire q_o
);

    reg meta_q;
    reg sync_q;

    // First stage feeds only the second stage
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule // sbcl_sync

/* File: core/sbcl_top.v */
// Boot strap latch: samples straps at reset release, decodes, APB readback
//
// Function
// - Sample all six strap pins during power-on reset, latching each bit.
// - Latched straps stay fixed until shutdown; later pin activity ignored.
// - Software reads the six latched strap bits from a read-only register.
// - Weak default pulls drive every strap pin while in reset.
// - After reset the strap pins return to their ordinary function.
// - Flash supply is 3.3V when ldo strap is 0, 1.8V when 1.
// - Boot select 1 boots SPI flash; both select and aux 0 download.
// - Boot log on uart0 transmit when log strap is 1, else silent.
// - Log and sdio straps pick SDIO slave input and output edges.
// - Firmware may override flash supply and SDIO edges after boot.
// - Chip enable is active high; device operates only while high.
`timescale 1ns/100ps
`include "sbcl_regs.vh"
module sbcl_top (
    // Clock, reset, clock enable
    input  wire                      core_clk_i,
    input  wire                      nrst_i,
    input  wire                      ce_i,
    // Chip enable pin
    input  wire                      chip_en_i,
    // Strap pads
    input  wire [`SBCL_STRAP_MSB:0]  strap_pad_i,
    output wire [`SBCL_STRAP_MSB:0]  strap_pad_o,
    output wire [`SBCL_STRAP_MSB:0]  strap_pad_oe_o,
    output reg  [`SBCL_STRAP_MSB:0]  strap_pull_up_o,
    output reg  [`SBCL_STRAP_MSB:0]  strap_pull_dn_o,
    // Ordinary pin functions behind the strap pads
    input  wire [`SBCL_STRAP_MSB:0]  func_out_i,
    input  wire [`SBCL_STRAP_MSB:0]  func_oe_i,
    output wire [`SBCL_STRAP_MSB:0]  func_in_o,
    // Boot log path
    input  wire                      uart0_tx_i,
    input  wire                      boot_done_i,
    output wire                      uart0_transmit_o,
    // Decoded settings
    output reg                       flash_vsel_1v8_o,
    output reg                       boot_spi_flash_o,
    output reg                       boot_download_o,
    output reg                       boot_log_en_o,
    output reg                       sdio_in_rising_o,
    output reg                       sdio_out_rising_o,
    output reg                       straps_valid_o,
    output wire                      core_run_o,
    // APB slave
    input  wire                      psel,
    input  wire                      penable,
    input  wire                      pwrite,
    input  wire [`SBCL_ADDR_W-1:0]   paddr,
    input  wire [31:0]               pwdata,
    output wire                      pready,
    output reg  [31:0]               prdata,
    output reg                       pslverr
);

    // Settle count, cut to the counter width on purpose
    localparam integer SETTLE_INT = `SBCL_SETTLE_CYC;
    localparam [`SBCL_CNT_W-1:0] SETTLE_CYC = SETTLE_INT[`SBCL_CNT_W-1:0];

    wire [`SBCL_STRAP_MSB:0] pad_sync;
    wire                     en_sync;

    reg                      phase_q;
    reg                      phase_d;
    reg [`SBCL_CNT_W-1:0]    cnt_q;
    reg [`SBCL_CNT_W-1:0]    cnt_d;
    reg [`SBCL_STRAP_MSB:0]  strap_q;
    reg                      valid_q;
    reg                      booting_q;
    reg [`SBCL_OV_MSB:0]     ovr_q;
    wire                     capture;
    wire                     run;

    // Pads and chip enable come from outside the clock domain
    genvar gi;
    generate
        for (gi = 0; gi < `SBCL_NSTRAP; gi = gi + 1) begin : g_pad
            sbcl_sync u_sync (
                .core_clk_i (core_clk_i),
                .nrst_i     (nrst_i),
                .ce_i       (ce_i),
                .d_i        (strap_pad_i[gi]),
                .q_o        (pad_sync[gi])
            );
        end
    endgenerate

    sbcl_sync u_en_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .d_i        (chip_en_i),
        .q_o        (en_sync)
    );

    // Hold phase lasts until enable is high and pads have settled;
    // the count starts only after the two synchroniser stages.
    always @* begin
        phase_d = phase_q;
        cnt_d   = cnt_q;
        case (phase_q)
            `SBCL_ST_HOLD: begin
                if (!en_sync) begin
                    cnt_d = `SBCL_CNT_ZERO;
                end else if (cnt_q == SETTLE_CYC) begin
                    phase_d = `SBCL_ST_RUN;
                end else begin
                    cnt_d = cnt_q + `SBCL_CNT_ONE;
                end
            end
            `SBCL_ST_RUN: begin
                if (!en_sync) begin
                    phase_d = `SBCL_ST_HOLD;
                    cnt_d   = `SBCL_CNT_ZERO;
                end
            end
            default: begin
                phase_d = `SBCL_ST_HOLD;
                cnt_d   = `SBCL_CNT_ZERO;
            end
        endcase
    end

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= `SBCL_ST_HOLD;
            cnt_q   <= `SBCL_CNT_ZERO;
        end else if (ce_i) begin
            phase_q <= phase_d;
            cnt_q   <= cnt_d;
        end
    end

    assign capture    = (phase_q == `SBCL_ST_HOLD) &&
                        (phase_d == `SBCL_ST_RUN);
    assign run        = (phase_q == `SBCL_ST_RUN);
    assign core_run_o = run;

    // Capture happens on the hold-to-run edge only; a shutdown keeps the
    // old straps in the latch but clears valid until the next capture.
    // sample straps once per release
    // no other path writes the latch
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_q <= `SBCL_STRAP_RST;
            valid_q <= 1'b0;
        end else if (ce_i) begin
            if (capture) begin
                strap_q <= pad_sync;
                valid_q <= 1'b1;
            end else if (!run && !en_sync) begin
                valid_q <= 1'b0;
            end
        end
    end

    // Boot phase ends on boot_done_i; the set at capture wins
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            booting_q <= 1'b0;
        end else if (ce_i) begin
            if (capture) begin
                booting_q <= 1'b1;
            end else if (boot_done_i || !run) begin
                booting_q <= 1'b0;
            end
        end
    end

    // Driven from phase_d so pulls drop on the edge the pads are handed
    // over; a late drop would fight a pad driven by its normal function.
    // weak pulls only while held in reset
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_pull_up_o <= `SBCL_PULLUP_MASK;
            strap_pull_dn_o <= `SBCL_PULLDN_MASK;
        end else if (ce_i) begin
            if (phase_d == `SBCL_ST_RUN) begin
                strap_pull_up_o <= `SBCL_STRAP_RST;
                strap_pull_dn_o <= `SBCL_STRAP_RST;
            end else begin
                strap_pull_up_o <= `SBCL_PULLUP_MASK;
                strap_pull_dn_o <= `SBCL_PULLDN_MASK;
            end
        end
    end

    // pads belong to their normal function once running
    assign strap_pad_o    = run ? func_out_i : `SBCL_STRAP_RST;
    assign strap_pad_oe_o = run ? func_oe_i  : `SBCL_STRAP_RST;
    assign func_in_o      = run ? pad_sync   : `SBCL_STRAP_RST;

    // silent line idles high during boot when logging is off
    assign uart0_transmit_o = (booting_q && !boot_log_en_o) ? 1'b1
                                                            : uart0_tx_i;

    // Decoded settings, registered so they never glitch
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flash_vsel_1v8_o  <= 1'b0;
            boot_spi_flash_o  <= 1'b0;
            boot_download_o   <= 1'b0;
            boot_log_en_o     <= 1'b0;
            sdio_in_rising_o  <= 1'b0;
            sdio_out_rising_o <= 1'b0;
            straps_valid_o    <= 1'b0;
        end else if (ce_i) begin
            straps_valid_o <= valid_q;
            // override only after straps are latched
            if (valid_q && ovr_q[`SBCL_OV_VSEL_EN]) begin
                flash_vsel_1v8_o <= ovr_q[`SBCL_OV_VSEL];
            end else begin
                flash_vsel_1v8_o <= strap_q[`SBCL_BIT_LDO];
            end
            boot_spi_flash_o <= valid_q & strap_q[`SBCL_BIT_BOOTSEL];
            boot_download_o  <= valid_q & ~strap_q[`SBCL_BIT_BOOTSEL] &
                                ~strap_q[`SBCL_BIT_BOOTAUX];
            boot_log_en_o    <= strap_q[`SBCL_BIT_LOG];
            // edge pair from log and sdio straps
            if (valid_q && ovr_q[`SBCL_OV_SDIO_EN]) begin
                sdio_in_rising_o  <= ovr_q[`SBCL_OV_SDIO_IN];
                sdio_out_rising_o <= ovr_q[`SBCL_OV_SDIO_OUT];
            end else begin
                sdio_in_rising_o  <= strap_q[`SBCL_BIT_LOG];
                sdio_out_rising_o <= strap_q[`SBCL_BIT_SDIO];
            end
        end
    end

    // APB: zero wait states. Read data and the error flag are taken into
    // flip-flops at the end of the setup cycle, so they stand for the whole
    // access cycle without a combinational path from the address pins.
    wire apb_setup  = psel & ~penable;
    wire apb_acc    = psel & penable;
    wire hit_status = (paddr == `SBCL_OFF_STATUS);
    wire hit_ovr    = (paddr == `SBCL_OFF_OVERRIDE);
    wire hit_eff    = (paddr == `SBCL_OFF_EFFECT);
    wire hit_any    = hit_status | hit_ovr | hit_eff;
    // Read-only registers refuse writes with an error
    wire bad_access = ~hit_any | (pwrite & ~hit_ovr);
    reg  [31:0] rd_mux;

    assign pready = 1'b1;

    always @* begin
        rd_mux = `SBCL_ZERO32;
        if (!pwrite) begin
            if (hit_status) begin
                // latched straps and their valid flag
                rd_mux[`SBCL_STRAP_MSB:0] = strap_q;
                rd_mux[`SBCL_ST_VALID]    = valid_q;
            end else if (hit_ovr) begin
                rd_mux[`SBCL_OV_MSB:0] = ovr_q;
            end else if (hit_eff) begin
                rd_mux[`SBCL_EF_VSEL]     = flash_vsel_1v8_o;
                rd_mux[`SBCL_EF_SDIO_IN]  = sdio_in_rising_o;
                rd_mux[`SBCL_EF_SDIO_OUT] = sdio_out_rising_o;
                rd_mux[`SBCL_EF_BOOT_SPI] = boot_spi_flash_o;
                rd_mux[`SBCL_EF_BOOT_DL]  = boot_download_o;
                rd_mux[`SBCL_EF_LOG]      = boot_log_en_o;
                rd_mux[`SBCL_EF_BOOTING]  = booting_q;
            end
        end
    end

    // Outside the access cycle both answers read as zero
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata  <= `SBCL_ZERO32;
            pslverr <= 1'b0;
        end else if (ce_i) begin
            if (apb_setup) begin
                prdata  <= rd_mux;
                pslverr <= bad_access;
            end else begin
                prdata  <= `SBCL_ZERO32;
                pslverr <= 1'b0;
            end
        end
    end

    // Override bits survive shutdown; only the core reset clears them
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ovr_q <= `SBCL_OV_RST;
        end else if (ce_i) begin
            if (apb_acc && pwrite && hit_ovr) begin
                ovr_q <= pwdata[`SBCL_OV_MSB:0];
            end
        end
    end

endmodule // sbcl_top

/* File: include/sbcl_regs.vh */
// Constants for the boot strap latch: strap layout, pulls, timing, registers
`ifndef SBCL_REGS_VH
`define SBCL_REGS_VH

// Strap vector layout
`define SBCL_NSTRAP          6
`define SBCL_STRAP_MSB       5
`define SBCL_BIT_LDO         0
`define SBCL_BIT_BOOTSEL     1
`define SBCL_BIT_BOOTAUX     2
`define SBCL_BIT_LOG         3
`define SBCL_BIT_SDIO        4
`define SBCL_BIT_SPARE       5

// Weak pulls applied while in reset
`define SBCL_PULLUP_MASK     6'h1A
`define SBCL_PULLDN_MASK     6'h25
`define SBCL_STRAP_RST       6'h00

// Settle time before capture, rounded up to whole cycles
`define SBCL_CLK_PERIOD_NS   10
`define SBCL_SETTLE_NS       200
`define SBCL_SETTLE_CYC      ((`SBCL_SETTLE_NS + `SBCL_CLK_PERIOD_NS - 1) \
                              / `SBCL_CLK_PERIOD_NS)
`define SBCL_CNT_W           8
`define SBCL_CNT_ZERO        8'h00
`define SBCL_CNT_ONE         8'h01

// Register byte offsets
`define SBCL_ADDR_W          12
`define SBCL_OFF_STATUS      12'h000
`define SBCL_OFF_OVERRIDE    12'h004
`define SBCL_OFF_EFFECT      12'h008

// Status register fields
`define SBCL_ST_VALID        8

// Override register fields
`define SBCL_OV_VSEL_EN      0
`define SBCL_OV_VSEL         1
`define SBCL_OV_SDIO_EN      2
`define SBCL_OV_SDIO_IN      3
`define SBCL_OV_SDIO_OUT     4
`define SBCL_OV_MSB          4
`define SBCL_OV_RST          5'h00

// Effective setting register fields
`define SBCL_EF_VSEL         0
`define SBCL_EF_SDIO_IN      1
`define SBCL_EF_SDIO_OUT     2
`define SBCL_EF_BOOT_SPI     3
`define SBCL_EF_BOOT_DL      4
`define SBCL_EF_LOG          5
`define SBCL_EF_BOOTING      6

// Phases
`define SBCL_ST_HOLD         1'b0
`define SBCL_ST_RUN          1'b1

`define SBCL_ZERO32          32'h0000_0000

`endif
